// >>> verilog/rss_pkg.sv
// shared constants and types for the rotate/subtract/skip datapath
`default_nettype none
package rss_pkg;
  localparam int unsigned  RSS_DATA_W     = 8;
  localparam int unsigned  RSS_ADDR_W     = 5;
  localparam int unsigned  RSS_MEM_DEPTH  = 32;
  localparam int unsigned  RSS_BIT_SEL_W  = 3;
  localparam int unsigned  RSS_MSB        = 7;
  localparam int unsigned  RSS_LSB        = 0;
  localparam int unsigned  RSS_NIB_W      = 4;
  localparam logic [7:0]   RSS_ALL_ONES   = 8'hff;
  localparam logic [7:0]   RSS_ZERO_BYTE  = 8'h00;
  localparam logic [7:0]   RSS_ONE_BYTE   = 8'h01;
  localparam logic [7:0]   RSS_WORK_RST   = 8'h00;
  localparam logic         RSS_CARRY_RST  = 1'b0;
  localparam logic         RSS_FLAG_RST   = 1'b0;
  localparam int unsigned  RSS_SKIP_DUMMY_CYCLES = 1;

  typedef enum logic [3:0] {
    RSS_OP_ROT_LEFT_THRU_TO_WORK  = 4'h0,
    RSS_OP_ROT_RIGHT              = 4'h1,
    RSS_OP_ROT_RIGHT_TO_WORK      = 4'h2,
    RSS_OP_ROT_RIGHT_THRU         = 4'h3,
    RSS_OP_ROT_RIGHT_THRU_TO_WORK = 4'h4,
    RSS_OP_SUB_BORROW             = 4'h5,
    RSS_OP_SUB_BORROW_TO_MEM      = 4'h6,
    RSS_OP_MINUS_TO_WORK          = 4'h7,
    RSS_OP_DEC_SKIP_ZERO          = 4'h8,
    RSS_OP_DEC_SKIP_ZERO_TO_WORK  = 4'h9,
    RSS_OP_INC_SKIP_ZERO          = 4'ha,
    RSS_OP_INC_SKIP_ZERO_TO_WORK  = 4'hb,
    RSS_OP_BIT_SET_SKIP           = 4'hc,
    RSS_OP_SET_BYTE               = 4'hd,
    RSS_OP_SET_BIT                = 4'he,
    RSS_OP_NONE                   = 4'hf
  } rss_op_t;

  typedef enum logic [1:0] {
    RSS_ST_IDLE  = 2'b00,
    RSS_ST_CALC  = 2'b01,
    RSS_ST_DUMMY = 2'b11
  } rss_state_t;
endpackage
`default_nettype wire

// >>> verilog/rss_data_mem.sv
// data memory: one write port, one read port with registered read data
`default_nettype none
module rss_data_mem
  import rss_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  wr_en,
  input  wire logic [RSS_ADDR_W-1:0] wr_addr,
  input  wire logic [RSS_DATA_W-1:0] wr_data,
  input  wire logic [RSS_ADDR_W-1:0] rd_addr,
  output var  logic [RSS_DATA_W-1:0] rd_data_q
);
  logic [RSS_DATA_W-1:0] mem_q [RSS_MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q <= mem_q[rd_addr];
  end
endmodule
`default_nettype wire

// >>> verilog/rss_datapath.sv
// rotate, subtract, skip and set datapath with its own data memory
// Functional notes
// - left rotate through carry into work register; old carry to bit 0, bit 7 to carry
// - rotate memory byte right in place, bit 0 into bit 7, no flags
// - right-rotated memory byte goes to work register; memory and flags unchanged
// - rotate memory right through carry in place; bit 0 to carry, carry to bit 7
// - same right rotate through carry, result only to work register, carry updated
// - work minus memory minus inverted carry, stored in work register
// - same borrow-inclusive difference written back to the memory byte
// - after subtraction carry is 0 when result negative, 1 when zero or positive
// - plain subtract into work register, updates overflow, zero, nibble carry, carry
// - decrement memory in place, skip next when result zero, no flags
// - memory minus one into work register, memory kept, skip when zero
// - increment memory in place, skip next when wrapped result zero, no flags
// - memory plus one into work register, memory kept, skip when zero
// - test selected memory bit, skip next when it is one
// - every skip-type operation takes two cycles with an inserted dummy cycle
// - byte set writes all ones to the memory byte, no flags
// - bit set forces only the selected bit to one, no flags
`default_nettype none
module rss_datapath
  import rss_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     op_valid,
  output logic                          op_ready,
  input  wire rss_op_t                  op_code,
  input  wire logic [RSS_ADDR_W-1:0]    op_addr,
  input  wire logic [RSS_BIT_SEL_W-1:0] op_bit,
  output var  logic                     op_done_q,
  output var  logic                     skip_next_q,
  input  wire logic                     mem_load_en,
  input  wire logic [RSS_ADDR_W-1:0]    mem_load_addr,
  input  wire logic [RSS_DATA_W-1:0]    mem_load_data,
  output logic [RSS_DATA_W-1:0]         mem_rd_data,
  input  wire logic                     work_load_en,
  input  wire logic [RSS_DATA_W-1:0]    work_load_data,
  input  wire logic                     carry_load_en,
  input  wire logic                     carry_load_data,
  output var  logic [RSS_DATA_W-1:0]    work_register_q,
  output var  logic                     borrow_out_bit_q,
  output var  logic                     arith_wrap_flag_q,
  output var  logic                     result_null_flag_q,
  output var  logic                     nibble_carry_flag_q
);
  rss_state_t                 state_q;
  rss_op_t                    op_q;
  logic [RSS_ADDR_W-1:0]      addr_q;
  logic [RSS_BIT_SEL_W-1:0]   bit_q;
  logic                       skip_hit_q;
  logic [RSS_DATA_W-1:0]      mem_byte;
  logic [RSS_DATA_W-1:0]      result;
  logic                       to_work;
  logic                       to_mem;
  logic                       is_sub;
  logic                       is_skip;
  logic                       carry_wr;
  logic                       carry_new;
  logic                       skip_hit;
  logic [RSS_DATA_W:0]        diff9;
  logic [RSS_NIB_W:0]         diff5;
  logic                       borrow_in;
  logic [RSS_DATA_W-1:0]      bit_mask;
  logic                       accept;
  logic                       calc;
  logic                       mem_wr_en;
  logic [RSS_ADDR_W-1:0]      mem_wr_addr;
  logic [RSS_DATA_W-1:0]      mem_wr_data;

  assign op_ready    = (state_q == RSS_ST_IDLE);
  assign accept      = op_ready && op_valid && (op_code != RSS_OP_NONE);
  assign calc        = (state_q == RSS_ST_CALC);
  assign mem_byte    = mem_rd_data;
  assign bit_mask    = RSS_ONE_BYTE << bit_q;

  // host preloads only reach the memory while no operation owns it
  assign mem_wr_en   = calc ? to_mem : (op_ready && mem_load_en);
  assign mem_wr_addr = calc ? addr_q : mem_load_addr;
  assign mem_wr_data = calc ? result : mem_load_data;

  rss_data_mem u_mem (
    .clk       (clk),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .rd_addr   (op_ready ? op_addr : addr_q),
    .rd_data_q (mem_rd_data)
  );

  // borrow-aware subtractor shared by the three subtract operations
  assign borrow_in = (op_q == RSS_OP_MINUS_TO_WORK) ? 1'b0 : ~borrow_out_bit_q;
  assign diff9 = {1'b0, work_register_q} - {1'b0, mem_byte} - {{RSS_DATA_W{1'b0}}, borrow_in};
  assign diff5 = {1'b0, work_register_q[RSS_NIB_W-1:0]} - {1'b0, mem_byte[RSS_NIB_W-1:0]}
               - {{RSS_NIB_W{1'b0}}, borrow_in};

  always_comb begin
    result    = mem_byte;
    to_work   = 1'b0;
    to_mem    = 1'b0;
    is_sub    = 1'b0;
    is_skip   = 1'b0;
    carry_wr  = 1'b0;
    carry_new = borrow_out_bit_q;
    skip_hit  = 1'b0;
    case (op_q)
      RSS_OP_ROT_LEFT_THRU_TO_WORK: begin
        result    = {mem_byte[RSS_MSB-1:0], borrow_out_bit_q};
        carry_new = mem_byte[RSS_MSB];
        carry_wr  = 1'b1;
        to_work   = 1'b1;
      end
      RSS_OP_ROT_RIGHT: begin
        result = {mem_byte[RSS_LSB], mem_byte[RSS_MSB:1]};
        to_mem = 1'b1;
      end
      RSS_OP_ROT_RIGHT_TO_WORK: begin
        result  = {mem_byte[RSS_LSB], mem_byte[RSS_MSB:1]};
        to_work = 1'b1;
      end
      RSS_OP_ROT_RIGHT_THRU: begin
        result    = {borrow_out_bit_q, mem_byte[RSS_MSB:1]};
        carry_new = mem_byte[RSS_LSB];
        carry_wr  = 1'b1;
        to_mem    = 1'b1;
      end
      RSS_OP_ROT_RIGHT_THRU_TO_WORK: begin
        result    = {borrow_out_bit_q, mem_byte[RSS_MSB:1]};
        carry_new = mem_byte[RSS_LSB];
        carry_wr  = 1'b1;
        to_work   = 1'b1;
      end
      RSS_OP_SUB_BORROW, RSS_OP_MINUS_TO_WORK: begin
        result  = diff9[RSS_DATA_W-1:0];
        is_sub  = 1'b1;
        to_work = 1'b1;
      end
      RSS_OP_SUB_BORROW_TO_MEM: begin
        result = diff9[RSS_DATA_W-1:0];
        is_sub = 1'b1;
        to_mem = 1'b1;
      end
      RSS_OP_DEC_SKIP_ZERO: begin
        result   = mem_byte - RSS_ONE_BYTE;
        to_mem   = 1'b1;
        is_skip  = 1'b1;
        skip_hit = (result == RSS_ZERO_BYTE);
      end
      RSS_OP_DEC_SKIP_ZERO_TO_WORK: begin
        result   = mem_byte - RSS_ONE_BYTE;
        to_work  = 1'b1;
        is_skip  = 1'b1;
        skip_hit = (result == RSS_ZERO_BYTE);
      end
      RSS_OP_INC_SKIP_ZERO: begin
        result   = mem_byte + RSS_ONE_BYTE;
        to_mem   = 1'b1;
        is_skip  = 1'b1;
        skip_hit = (result == RSS_ZERO_BYTE);
      end
      RSS_OP_INC_SKIP_ZERO_TO_WORK: begin
        result   = mem_byte + RSS_ONE_BYTE;
        to_work  = 1'b1;
        is_skip  = 1'b1;
        skip_hit = (result == RSS_ZERO_BYTE);
      end
      RSS_OP_BIT_SET_SKIP: begin
        is_skip  = 1'b1;
        skip_hit = |(mem_byte & bit_mask);
      end
      RSS_OP_SET_BYTE: begin
        result = RSS_ALL_ONES;
        to_mem = 1'b1;
      end
      RSS_OP_SET_BIT: begin
        result = mem_byte | bit_mask;
        to_mem = 1'b1;
      end
      default: begin
        result = mem_byte;
      end
    endcase
    if (is_sub) begin
      carry_wr  = 1'b1;
      carry_new = ~diff9[RSS_DATA_W];
    end
  end

  // operation sequencing: calc, then one dummy cycle for skip-type operations
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= RSS_ST_IDLE;
    end else begin
      case (state_q)
        RSS_ST_IDLE:  state_q <= accept ? RSS_ST_CALC : RSS_ST_IDLE;
        RSS_ST_CALC:  state_q <= is_skip ? RSS_ST_DUMMY : RSS_ST_IDLE;
        RSS_ST_DUMMY: state_q <= RSS_ST_IDLE;
        default:      state_q <= RSS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q   <= RSS_OP_NONE;
      addr_q <= '0;
      bit_q  <= '0;
    end else if (accept) begin
      op_q   <= op_code;
      addr_q <= op_addr;
      bit_q  <= op_bit;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_hit_q <= 1'b0;
    end else if (calc) begin
      skip_hit_q <= skip_hit;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_done_q   <= 1'b0;
      skip_next_q <= 1'b0;
    end else begin
      op_done_q   <= (calc && !is_skip) || (state_q == RSS_ST_DUMMY);
      skip_next_q <= (state_q == RSS_ST_DUMMY) && skip_hit_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      work_register_q <= RSS_WORK_RST;
    end else if (calc && to_work) begin
      work_register_q <= result;
    end else if (op_ready && work_load_en) begin
      work_register_q <= work_load_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      borrow_out_bit_q <= RSS_CARRY_RST;
    end else if (calc && carry_wr) begin
      borrow_out_bit_q <= carry_new;
    end else if (op_ready && carry_load_en) begin
      borrow_out_bit_q <= carry_load_data;
    end
  end

  // only subtractions touch the remaining status flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arith_wrap_flag_q   <= RSS_FLAG_RST;
      result_null_flag_q  <= RSS_FLAG_RST;
      nibble_carry_flag_q <= RSS_FLAG_RST;
    end else if (calc && is_sub) begin
      result_null_flag_q  <= (diff9[RSS_DATA_W-1:0] == RSS_ZERO_BYTE);
      arith_wrap_flag_q   <= (work_register_q[RSS_MSB] ^ mem_byte[RSS_MSB])
                           & (work_register_q[RSS_MSB] ^ diff9[RSS_MSB]);
      nibble_carry_flag_q <= ~diff5[RSS_NIB_W];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_skip_op_taken;
    accept && (op_code inside {[RSS_OP_DEC_SKIP_ZERO:RSS_OP_BIT_SET_SKIP]});
  endsequence

  sequence s_plain_op_taken;
    accept && !(op_code inside {[RSS_OP_DEC_SKIP_ZERO:RSS_OP_BIT_SET_SKIP]});
  endsequence

  chk_skip_two_cycles: assert property (s_skip_op_taken |=> !op_done_q ##1 !op_done_q ##1 op_done_q)
    else $error("skip operation did not finish in two cycles");

  chk_plain_one_cycle: assert property (s_plain_op_taken |-> ##2 op_done_q)
    else $error("plain operation did not finish after one cycle");

  chk_sub_carry: assert property (calc && is_sub |=> borrow_out_bit_q == !$past(diff9[RSS_DATA_W]))
    else $error("subtract carry does not follow sign of result");

  chk_sub_zero: assert property (calc && is_sub |=> result_null_flag_q == ($past(result) == RSS_ZERO_BYTE))
    else $error("zero flag mismatch after subtraction");

  chk_rot_right_work: assert property (calc && op_q == RSS_OP_ROT_RIGHT_TO_WORK
    |=> work_register_q == {$past(mem_byte[RSS_LSB]), $past(mem_byte[RSS_MSB:1])}
        && $stable(borrow_out_bit_q))
    else $error("right rotate to work register wrong");

  chk_rotate_left_thru_flag_to_work_carry: assert property (calc && op_q == RSS_OP_ROT_LEFT_THRU_TO_WORK
    |=> borrow_out_bit_q == $past(mem_byte[RSS_MSB])
        && work_register_q[RSS_LSB] == $past(borrow_out_bit_q))
    else $error("left rotate through carry wrong");

  chk_rrc_mem: assert property (calc && op_q == RSS_OP_ROT_RIGHT_THRU
    |-> mem_wr_en && mem_wr_data[RSS_MSB] == borrow_out_bit_q ##1 borrow_out_bit_q == $past(mem_byte[RSS_LSB]))
    else $error("right rotate through carry wrong");

  chk_skip_flags: assert property (calc && is_skip |=> $stable(borrow_out_bit_q) && $stable(result_null_flag_q)
    && $stable(arith_wrap_flag_q) && $stable(nibble_carry_flag_q))
    else $error("skip operation changed a flag");

  chk_dec_skip: assert property (calc && op_q == RSS_OP_DEC_SKIP_ZERO && mem_byte == RSS_ONE_BYTE
    |-> mem_wr_en && mem_wr_data == RSS_ZERO_BYTE ##2 skip_next_q && op_done_q)
    else $error("decrement to zero did not skip");

  chk_bit_skip: assert property (calc && op_q == RSS_OP_BIT_SET_SKIP && (mem_byte & bit_mask) == RSS_ZERO_BYTE
    |-> !mem_wr_en ##2 !skip_next_q)
    else $error("bit test skipped on a clear bit");

  chk_set_byte: assert property (calc && op_q == RSS_OP_SET_BYTE |-> mem_wr_en && mem_wr_data == RSS_ALL_ONES)
    else $error("byte set did not write all ones");

  chk_set_bit: assert property (calc && op_q == RSS_OP_SET_BIT
    |-> mem_wr_en && mem_wr_data == (mem_byte | bit_mask) ##1 $stable(borrow_out_bit_q))
    else $error("bit set wrong");
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the rotate/subtract/skip datapath
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     clk;
  logic                     sys_rst;
  logic                     op_valid;
  logic                     op_ready;
  rss_op_t                  op_code;
  logic [RSS_ADDR_W-1:0]    op_addr;
  logic [RSS_BIT_SEL_W-1:0] op_bit;
  logic                     op_done_q;
  logic                     skip_next_q;
  logic                     mem_load_en;
  logic [RSS_ADDR_W-1:0]    mem_load_addr;
  logic [RSS_DATA_W-1:0]    mem_load_data;
  logic [RSS_DATA_W-1:0]    mem_rd_data;
  logic                     work_load_en;
  logic [RSS_DATA_W-1:0]    work_load_data;
  logic                     carry_load_en;
  logic                     carry_load_data;
  logic [RSS_DATA_W-1:0]    work_register_q;
  logic                     borrow_out_bit_q;
  logic                     arith_wrap_flag_q;
  logic                     result_null_flag_q;
  logic                     nibble_carry_flag_q;
  int                       mismatches;
  int                       n_compared;
  logic [RSS_ADDR_W-1:0]    cur_addr;
  logic                     e_wrap;
  logic                     e_null;
  logic                     e_nib;

  rss_datapath rss_datapath_i (
    .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_done_q(op_done_q), .skip_next_q(skip_next_q),
    .mem_load_en(mem_load_en), .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
    .mem_rd_data(mem_rd_data), .work_load_en(work_load_en), .work_load_data(work_load_data),
    .carry_load_en(carry_load_en), .carry_load_data(carry_load_data), .work_register_q(work_register_q),
    .borrow_out_bit_q(borrow_out_bit_q), .arith_wrap_flag_q(arith_wrap_flag_q),
    .result_null_flag_q(result_null_flag_q), .nibble_carry_flag_q(nibble_carry_flag_q)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // seeds memory, work and carry, runs one op and checks every visible result against a local model
  task automatic run(input rss_op_t op, input logic [7:0] m, input logic [7:0] w, input logic c,
                     input logic [2:0] b);
    logic [7:0] ew;
    logic [7:0] em;
    logic [7:0] r;
    logic [8:0] d9;
    logic [4:0] d5;
    logic       ec;
    logic       es;
    logic       bin;
    int         ecyc;
    int         n;
    ew = w; em = m; ec = c; es = 1'b0; ecyc = 2;
    case (op)
      RSS_OP_ROT_LEFT_THRU_TO_WORK:  begin ew = {m[6:0], c}; ec = m[7]; end
      RSS_OP_ROT_RIGHT:              em = {m[0], m[7:1]};
      RSS_OP_ROT_RIGHT_TO_WORK:      ew = {m[0], m[7:1]};
      RSS_OP_ROT_RIGHT_THRU:         begin em = {c, m[7:1]}; ec = m[0]; end
      RSS_OP_ROT_RIGHT_THRU_TO_WORK: begin ew = {c, m[7:1]}; ec = m[0]; end
      RSS_OP_SUB_BORROW, RSS_OP_SUB_BORROW_TO_MEM, RSS_OP_MINUS_TO_WORK: begin
        bin = (op == RSS_OP_MINUS_TO_WORK) ? 1'b0 : ~c;
        d9 = {1'b0, w} - {1'b0, m} - {8'h00, bin};
        d5 = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
        r = d9[7:0];
        ec = ~d9[8];
        e_nib = ~d5[4];
        e_null = (r == 8'h00);
        e_wrap = (w[7] != m[7]) && (r[7] != w[7]);
        if (op == RSS_OP_SUB_BORROW_TO_MEM) em = r;
        else ew = r;
      end
      RSS_OP_DEC_SKIP_ZERO:          begin em = m - 8'h01; es = (em == 8'h00); ecyc = 3; end
      RSS_OP_DEC_SKIP_ZERO_TO_WORK:  begin ew = m - 8'h01; es = (ew == 8'h00); ecyc = 3; end
      RSS_OP_INC_SKIP_ZERO:          begin em = m + 8'h01; es = (em == 8'h00); ecyc = 3; end
      RSS_OP_INC_SKIP_ZERO_TO_WORK:  begin ew = m + 8'h01; es = (ew == 8'h00); ecyc = 3; end
      RSS_OP_BIT_SET_SKIP:           begin es = m[b]; ecyc = 3; end
      RSS_OP_SET_BYTE:               em = 8'hff;
      RSS_OP_SET_BIT:                em = m | (8'h01 << b);
      default:                       ecyc = 2;
    endcase
    mem_load_en = 1'b1; mem_load_addr = cur_addr; mem_load_data = m;
    work_load_en = 1'b1; work_load_data = w;
    carry_load_en = 1'b1; carry_load_data = c;
    @(negedge clk);
    mem_load_en = 1'b0; work_load_en = 1'b0; carry_load_en = 1'b0;
    op_valid = 1'b1; op_code = op; op_addr = cur_addr; op_bit = b;
    @(negedge clk);
    op_valid = 1'b0;
    `CHK("busy", 1'b0, op_ready)
    n = 1;
    while (op_done_q !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    `CHK("cycles", ecyc, n)
    `CHK("ready", 1'b1, op_ready)
    `CHK("skip", es, skip_next_q)
    `CHK("work", ew, work_register_q)
    `CHK("carry", ec, borrow_out_bit_q)
    `CHK("wrap", e_wrap, arith_wrap_flag_q)
    `CHK("null", e_null, result_null_flag_q)
    `CHK("nibble", e_nib, nibble_carry_flag_q)
    @(negedge clk);
    `CHK("mem", em, mem_rd_data)
    cur_addr = cur_addr + 5'd1;
  endtask

  initial begin
    sys_rst = 1'b1; op_valid = 1'b0; op_code = RSS_OP_NONE; op_addr = '0; op_bit = '0;
    mem_load_en = 1'b0; mem_load_addr = '0; mem_load_data = '0;
    work_load_en = 1'b0; work_load_data = '0; carry_load_en = 1'b0; carry_load_data = 1'b0;
    mismatches = 0; n_compared = 0; cur_addr = 5'd3; e_wrap = 1'b0; e_null = 1'b0; e_nib = 1'b0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    `CHK("rst work", 8'h00, work_register_q)
    `CHK("rst flags", 4'h0, {borrow_out_bit_q, arith_wrap_flag_q, result_null_flag_q, nibble_carry_flag_q})
    `CHK("rst ready", 1'b1, op_ready)
    // the idle code is ignored even with a request raised
    op_valid = 1'b1;
    @(negedge clk);
    `CHK("none ready", 1'b1, op_ready)
    op_valid = 1'b0;
    @(negedge clk);
    `CHK("none done", 1'b0, op_done_q)
    run(RSS_OP_ROT_LEFT_THRU_TO_WORK, 8'h81, 8'h00, 1'b0, 3'd0);
    run(RSS_OP_ROT_LEFT_THRU_TO_WORK, 8'h2a, 8'h00, 1'b1, 3'd0);
    run(RSS_OP_ROT_RIGHT, 8'h81, 8'h5a, 1'b1, 3'd0);
    run(RSS_OP_ROT_RIGHT_TO_WORK, 8'h03, 8'h00, 1'b0, 3'd0);
    run(RSS_OP_ROT_RIGHT_THRU, 8'h01, 8'h00, 1'b0, 3'd0);
    run(RSS_OP_ROT_RIGHT_THRU, 8'h80, 8'h00, 1'b1, 3'd0);
    run(RSS_OP_ROT_RIGHT_THRU_TO_WORK, 8'h55, 8'h00, 1'b1, 3'd0);
    run(RSS_OP_SUB_BORROW, 8'h20, 8'h50, 1'b0, 3'd0);
    run(RSS_OP_SUB_BORROW, 8'h10, 8'h10, 1'b1, 3'd0);
    run(RSS_OP_SUB_BORROW, 8'h01, 8'h80, 1'b1, 3'd0);
    run(RSS_OP_SUB_BORROW_TO_MEM, 8'h07, 8'h05, 1'b1, 3'd0);
    run(RSS_OP_SUB_BORROW_TO_MEM, 8'h0f, 8'h1f, 1'b0, 3'd0);
    run(RSS_OP_MINUS_TO_WORK, 8'hff, 8'h7f, 1'b0, 3'd0);
    run(RSS_OP_MINUS_TO_WORK, 8'h33, 8'h33, 1'b0, 3'd0);
    run(RSS_OP_DEC_SKIP_ZERO, 8'h01, 8'h11, 1'b1, 3'd0);
    run(RSS_OP_DEC_SKIP_ZERO, 8'h00, 8'h11, 1'b0, 3'd0);
    run(RSS_OP_DEC_SKIP_ZERO_TO_WORK, 8'h01, 8'h22, 1'b0, 3'd0);
    run(RSS_OP_DEC_SKIP_ZERO_TO_WORK, 8'h05, 8'h22, 1'b1, 3'd0);
    run(RSS_OP_INC_SKIP_ZERO, 8'hff, 8'h44, 1'b0, 3'd0);
    run(RSS_OP_INC_SKIP_ZERO, 8'h10, 8'h44, 1'b1, 3'd0);
    run(RSS_OP_INC_SKIP_ZERO_TO_WORK, 8'hff, 8'h66, 1'b1, 3'd0);
    run(RSS_OP_INC_SKIP_ZERO_TO_WORK, 8'h7f, 8'h66, 1'b0, 3'd0);
    run(RSS_OP_BIT_SET_SKIP, 8'h80, 8'h00, 1'b0, 3'd7);
    run(RSS_OP_BIT_SET_SKIP, 8'h7f, 8'h00, 1'b1, 3'd7);
    run(RSS_OP_BIT_SET_SKIP, 8'hfe, 8'h00, 1'b0, 3'd0);
    run(RSS_OP_SET_BYTE, 8'h00, 8'h12, 1'b1, 3'd0);
    run(RSS_OP_SET_BIT, 8'h00, 8'h34, 1'b0, 3'd3);
    run(RSS_OP_SET_BIT, 8'h80, 8'h34, 1'b1, 3'd0);
    // a reset while an operation is in flight drops it and clears the visible state
    op_valid = 1'b1; op_code = RSS_OP_INC_SKIP_ZERO; op_addr = cur_addr;
    @(negedge clk);
    op_valid = 1'b0; sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0; e_wrap = 1'b0; e_null = 1'b0; e_nib = 1'b0;
    `CHK("mid rst ready", 1'b1, op_ready)
    `CHK("mid rst work", 8'h00, work_register_q)
    `CHK("mid rst flags", 4'h0, {borrow_out_bit_q, arith_wrap_flag_q, result_null_flag_q, nibble_carry_flag_q})
    @(negedge clk);
    `CHK("mid rst done", 2'b00, {op_done_q, skip_next_q})
    run(RSS_OP_SUB_BORROW, 8'h01, 8'h01, 1'b1, 3'd0);
    summarize();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
